// [raster_params.svh]
/*
  constants for the raster timing parameter set: legal ranges,
  reset timing, clock rate and measurement window.
  assumes: included by bare name, before the package and modules.
*/
`ifndef RASTER_PARAMS_SVH
`define RASTER_PARAMS_SVH

// ==========================================================
// legal ranges
`define H_FRONT_MAX 10'h280
`define H_SYNC_MIN 10'h010
`define H_SYNC_MAX 10'h280
`define H_BACK_MAX 10'h280
`define H_ACTIVE_MIN 11'h010
`define H_ACTIVE_MAX 11'h780
`define V_FRONT_MAX 10'h200
`define V_SYNC_MIN 6'h02
`define V_SYNC_MAX 6'h20
`define V_BACK_MAX 10'h200
`define V_ACTIVE_MIN 11'h00C
`define V_ACTIVE_MAX 11'h5A0

// ==========================================================
// reset timing (640 x 480 progressive, separate syncs)
`define RST_H_FRONT 10'h010
`define RST_H_SYNC 10'h060
`define RST_H_BACK 10'h030
`define RST_H_ACTIVE 11'h280
`define RST_V_FRONT 10'h00A
`define RST_V_SYNC 6'h02
`define RST_V_BACK 10'h021
`define RST_V_ACTIVE 11'h1E0

// ==========================================================
// clock and line rate measurement
`define CLK_PERIOD_NS 8
`define CLK_FREQ_KHZ 125000
`define RATE_GATE_MS 10
`define LINE_RATE_MIN_HZ 12500
`define LINE_RATE_MAX_HZ 125000
`define VSEP_CYCLES_DEF 1280

`endif

// [raster_pkg.sv]
/*
  types and shared decode for the raster timing parameter set.
  assumes: raster_params.svh is on the include path.
*/
`include "raster_params.svh"

package raster_pkg;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        SYNC_3W = 3'h3,
        SYNC_4W = 3'h4,
        SYNC_5W = 3'h5
    } sync_fmt_t;

    typedef enum logic {
        SET_IN = 1'b0,
        SET_OUT = 1'b1
    } set_sel_t;

    typedef enum logic {
        Q_IDLE = 1'b0,
        Q_SEND = 1'b1
    } query_state_t;

    typedef struct packed {
        logic [9:0] h_front;
        logic [9:0] h_sync_width;
        logic [9:0] h_back;
        logic [10:0] h_active;
        logic [9:0] v_front;
        logic [5:0] v_sync_width;
        logic [9:0] v_back;
        logic [10:0] v_active;
        sync_fmt_t sync_fmt;
        logic h_sync_polarity;
        logic v_sync_polarity;
        logic interlace_flag;
    } timing_set_t;

    typedef struct packed {
        logic h;
        logic v;
        logic c;
        logic sog;
    } raster_sync_t;

    // ==========================================================
    // shared decode
    function automatic logic timing_legal(timing_set_t s);
        return s.h_front <= `H_FRONT_MAX
            && s.h_sync_width >= `H_SYNC_MIN
            && s.h_sync_width <= `H_SYNC_MAX
            && s.h_back <= `H_BACK_MAX
            && s.h_active >= `H_ACTIVE_MIN
            && s.h_active <= `H_ACTIVE_MAX
            && s.v_front <= `V_FRONT_MAX
            && s.v_sync_width >= `V_SYNC_MIN
            && s.v_sync_width <= `V_SYNC_MAX
            && s.v_back <= `V_BACK_MAX
            && s.v_active >= `V_ACTIVE_MIN
            && s.v_active <= `V_ACTIVE_MAX
            && (s.sync_fmt == SYNC_3W || s.sync_fmt == SYNC_4W
                || s.sync_fmt == SYNC_5W);
    endfunction : timing_legal

    // three-wire sync is always negative
    function automatic logic eff_pol(sync_fmt_t f, logic p);
        return (f == SYNC_3W) ? 1'b0 : p;
    endfunction : eff_pol

endpackage : raster_pkg

// [line_rate_meter.sv]
/*
  line_rate_meter: measures line rate and lines per frame of the
  incoming raster, picking the sync wiring from the format setting.
  assumes: sync pins synchronous to clk; set stable while measuring.
*/
`timescale 1ns/1ps
`default_nettype none

module line_rate_meter #(
    parameter int GATE_CYCLES = 1250000,
    parameter int VSEP_CYCLES = 1280,
    parameter int RATE_MIN = 125,
    parameter int RATE_MAX = 1250
) (
    input wire logic clk,
    input wire logic nrst,
    input wire raster_pkg::raster_sync_t in_sync,
    input wire raster_pkg::sync_fmt_t sync_fmt,
    input wire logic h_pol,
    input wire logic v_pol,
    output logic [15:0] measured_line_rate,
    output logic [11:0] measured_total_lines,
    output logic total_valid,
    output logic line_rate_in_range
);
    import raster_pkg::*;

    // ==========================================================
    // sync separation
    logic comp_act, h_act, v_act, h_prev_q, v_prev_q;
    logic line_pulse, frame_pulse, gate_done;
    logic [15:0] comp_run_q, gate_lines_q;
    logic [11:0] line_cnt_q;
    logic [31:0] gate_cnt_q;

    always_comb
    begin
        comp_act = (sync_fmt == SYNC_3W) ? ~in_sync.sog
                 : in_sync.c ^ ~eff_pol(sync_fmt, h_pol);
        if (sync_fmt == SYNC_5W)
        begin
            h_act = in_sync.h ^ ~eff_pol(sync_fmt, h_pol);
            v_act = in_sync.v ^ ~eff_pol(sync_fmt, v_pol);
        end
        else
        begin
            // a composite pulse longer than any line sync is vertical
            h_act = comp_act;
            v_act = comp_run_q >= 16'(VSEP_CYCLES);
        end
    end

    assign line_pulse = h_act && !h_prev_q;
    assign frame_pulse = v_act && !v_prev_q;
    assign gate_done = gate_cnt_q == 32'(GATE_CYCLES - 1);

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            comp_run_q <= 16'h0000;
            h_prev_q <= 1'b0;
            v_prev_q <= 1'b0;
        end
        else
        begin
            if (!comp_act)
                comp_run_q <= 16'h0000;
            else if (comp_run_q != 16'hFFFF)
                comp_run_q <= comp_run_q + 16'h0001;
            h_prev_q <= h_act;
            v_prev_q <= v_act;
        end
    end

    // ==========================================================
    // lines per frame
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            line_cnt_q <= 12'h000;
            measured_total_lines <= 12'h000;
            total_valid <= 1'b0;
        end
        else if (frame_pulse)
        begin
            measured_total_lines <= line_cnt_q;
            total_valid <= 1'b1;
            line_cnt_q <= {11'h000, line_pulse};
        end
        else if (line_pulse && line_cnt_q != 12'hFFF)
            line_cnt_q <= line_cnt_q + 12'h001;
    end

    // ==========================================================
    // line rate over a fixed gate; result in lines per gate
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            gate_cnt_q <= 32'h0000_0000;
            gate_lines_q <= 16'h0000;
            measured_line_rate <= 16'h0000;
            line_rate_in_range <= 1'b0;
        end
        else if (gate_done)
        begin
            gate_cnt_q <= 32'h0000_0000;
            // a line edge on the gate end cycle opens the next gate
            gate_lines_q <= {15'h0000, line_pulse};
            measured_line_rate <= gate_lines_q;
            line_rate_in_range <= gate_lines_q >= 16'(RATE_MIN)
                && gate_lines_q <= 16'(RATE_MAX);
        end
        else
        begin
            gate_cnt_q <= gate_cnt_q + 32'h0000_0001;
            if (line_pulse && gate_lines_q != 16'hFFFF)
                gate_lines_q <= gate_lines_q + 16'h0001;
        end
    end

    a_rate_gate_only: assert property (@(posedge clk) disable iff (!nrst)
        !$past(gate_done) |-> $stable(measured_line_rate))
        else $error("line rate changed outside gate end");

endmodule : line_rate_meter

`default_nettype wire

// [raster_timing_parameter_set.sv]
/*
  raster_timing_parameter_set: input and output timing sets, query
  stream, output raster generator and input raster measurement.
  assumes: single clock, writes and queries synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "raster_params.svh"

// Contract
// - separate input and output timing sets, same fields and ranges
// - query returns h front, sync, back, active then v same order
// - h front porch opens blanking, h back closes; each 0 to 640
// - h sync width legal from 16 to 640 pixels
// - h blanking total is front porch plus sync plus back porch
// - active pixels per line legal from 16 to 1920
// - pixels per line is active plus front, sync and back
// - v front porch and v back porch each 0 to 512 lines
// - v sync width legal from 2 to 32 lines
// - active lines per frame legal from 12 to 1440
// - total lines measured, read only; front+sync+active checked
// - line rate measured over 12.5 to 125 kHz, read only
// - sync format 3, 4 or 5 wires, steers analog input only; the output set's format still sets the output sync polarity
// - 3 wire: sync on green; 4 wire: composite on one wire
// - 5 wire: h and v sync each on own wire
// - polarity flag 1 is positive sync, 0 negative
// - three-wire sync forces negative polarity on both syncs

module raster_timing_parameter_set #(
    parameter int GATE_CYCLES = `CLK_FREQ_KHZ * `RATE_GATE_MS,
    parameter int VSEP_CYCLES = `VSEP_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire raster_pkg::set_sel_t wr_sel,
    input wire raster_pkg::timing_set_t wr_data,
    output logic wr_error,
    input wire logic query_req,
    input wire raster_pkg::set_sel_t query_sel,
    output logic query_busy,
    output logic query_valid,
    output logic [2:0] query_index,
    output logic [10:0] query_word,
    output raster_pkg::timing_set_t in_set,
    output raster_pkg::timing_set_t out_set,
    input wire raster_pkg::raster_sync_t in_sync,
    output raster_pkg::raster_sync_t out_sync,
    output logic out_blank,
    output logic out_field,
    output logic [11:0] h_blank_total,
    output logic [11:0] h_line_total,
    output logic [15:0] measured_line_rate,
    output logic [11:0] measured_total_lines,
    output logic line_rate_in_range,
    output logic v_sum_mismatch
);
    import raster_pkg::*;

    // ==========================================================
    // constants
    localparam int RATE_MIN =
        `LINE_RATE_MIN_HZ * `RATE_GATE_MS / 1000;
    localparam int RATE_MAX =
        `LINE_RATE_MAX_HZ * `RATE_GATE_MS / 1000;
    localparam timing_set_t RESET_SET = '{
        h_front: `RST_H_FRONT,
        h_sync_width: `RST_H_SYNC,
        h_back: `RST_H_BACK,
        h_active: `RST_H_ACTIVE,
        v_front: `RST_V_FRONT,
        v_sync_width: `RST_V_SYNC,
        v_back: `RST_V_BACK,
        v_active: `RST_V_ACTIVE,
        sync_fmt: SYNC_5W,
        h_sync_polarity: 1'b0,
        v_sync_polarity: 1'b0,
        interlace_flag: 1'b0
    };

    // ==========================================================
    // query word select
    function automatic logic [10:0] set_word(timing_set_t s,
                                             logic [2:0] i);
        logic [10:0] w;
        w = 11'h000;
        unique case (i)
            3'h0: w = {1'b0, s.h_front};
            3'h1: w = {1'b0, s.h_sync_width};
            3'h2: w = {1'b0, s.h_back};
            3'h3: w = s.h_active;
            3'h4: w = {1'b0, s.v_front};
            3'h5: w = {5'h00, s.v_sync_width};
            3'h6: w = {1'b0, s.v_back};
            3'h7: w = s.v_active;
        endcase
        return w;
    endfunction : set_word

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // ==========================================================
    // parameter sets
    logic wr_ok;
    assign wr_ok = timing_legal(wr_data);

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            in_set <= RESET_SET;
            out_set <= RESET_SET;
        end
        else if (wr_en && wr_ok)
        begin
            if (wr_sel == SET_IN)
                in_set <= wr_data;
            else
                out_set <= wr_data;
        end
    end

    // illegal values leave the set untouched
    always_ff @(posedge clk)
    begin
        if (!nrst)
            wr_error <= 1'b0;
        else
            wr_error <= wr_en && !wr_ok;
    end

    a_illegal_keep: assert property (wr_en && !wr_ok |=>
        wr_error && $stable(in_set) && $stable(out_set))
        else $error("illegal timing write was accepted");

    a_sets_apart: assert property (wr_en && wr_sel == SET_IN |=>
        $stable(out_set))
        else $error("input set write altered output set");

    // ==========================================================
    // query stream
    query_state_t q_state_q;
    set_sel_t q_sel_q;
    logic q_take;
    timing_set_t q_live;

    assign q_take = query_req && q_state_q == Q_IDLE;
    assign query_busy = q_state_q == Q_SEND;
    assign q_live = (q_sel_q == SET_IN) ? in_set : out_set;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            q_state_q <= Q_IDLE;
            q_sel_q <= SET_IN;
            query_valid <= 1'b0;
            query_index <= 3'h0;
            query_word <= 11'h000;
        end
        else if (q_take)
        begin
            q_state_q <= Q_SEND;
            q_sel_q <= query_sel;
            query_valid <= 1'b1;
            query_index <= 3'h0;
            query_word <= set_word(
                (query_sel == SET_IN) ? in_set : out_set, 3'h0);
        end
        else if (q_state_q == Q_SEND)
        begin
            if (query_index == 3'h7)
            begin
                q_state_q <= Q_IDLE;
                query_valid <= 1'b0;
            end
            else
            begin
                query_index <= query_index + 3'h1;
                query_word <= set_word(q_live,
                                       query_index + 3'h1);
            end
        end
    end

    sequence q_words;
        (query_valid && query_index == 3'h0) ##1
        (query_valid && query_index == 3'h1) ##1
        (query_valid && query_index == 3'h2) ##1
        (query_valid && query_index == 3'h3) ##1
        (query_valid && query_index == 3'h4) ##1
        (query_valid && query_index == 3'h5) ##1
        (query_valid && query_index == 3'h6) ##1
        (query_valid && query_index == 3'h7) ##1 !query_valid;
    endsequence

    a_query_order: assert property (q_take |=> q_words)
        else $error("query words out of order");

    a_query_first: assert property (q_take && query_sel == SET_IN
        && !wr_en |=> query_word == {1'b0, in_set.h_front})
        else $error("first query word is not h front porch");

    // ==========================================================
    // output raster generator
    logic [11:0] h_cnt_q, v_cnt_q, h_end, v_end;
    logic [11:0] h_sync_lo, h_sync_hi, v_sync_lo, v_sync_hi;
    logic h_act_win, v_act_win, h_sync_win, v_sync_win, line_end;
    logic h_pol_eff, v_pol_eff, h_sync_q, v_sync_q, h_run_ok_q;
    logic [11:0] h_run_q;

    always_comb
    begin
        h_sync_lo = 12'(out_set.h_active) + 12'(out_set.h_front);
        h_sync_hi = h_sync_lo + 12'(out_set.h_sync_width);
        h_end = h_sync_hi + 12'(out_set.h_back) - 12'h001;
        v_sync_lo = 12'(out_set.v_active) + 12'(out_set.v_front);
        v_sync_hi = v_sync_lo + 12'(out_set.v_sync_width);
        v_end = v_sync_hi + 12'(out_set.v_back) - 12'h001;
    end

    assign h_act_win = h_cnt_q < 12'(out_set.h_active);
    assign v_act_win = v_cnt_q < 12'(out_set.v_active);
    assign h_sync_win = h_cnt_q >= h_sync_lo && h_cnt_q < h_sync_hi;
    assign v_sync_win = v_cnt_q >= v_sync_lo && v_cnt_q < v_sync_hi;
    assign line_end = h_cnt_q >= h_end;
    assign h_pol_eff = eff_pol(out_set.sync_fmt, out_set.h_sync_polarity);
    assign v_pol_eff = eff_pol(out_set.sync_fmt, out_set.v_sync_polarity);

    // >= rather than == so a shrunk set mid-line still wraps
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            h_cnt_q <= 12'h000;
            v_cnt_q <= 12'h000;
        end
        else if (line_end)
        begin
            h_cnt_q <= 12'h000;
            v_cnt_q <= (v_cnt_q >= v_end) ? 12'h000 : v_cnt_q + 12'h001;
        end
        else
            h_cnt_q <= h_cnt_q + 12'h001;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            h_sync_q <= 1'b0;
            v_sync_q <= 1'b0;
            out_blank <= 1'b1;
            out_sync <= 4'h0;
        end
        else
        begin
            h_sync_q <= h_sync_win;
            v_sync_q <= v_sync_win;
            out_blank <= !(h_act_win && v_act_win);
            out_sync.h <= h_sync_win ? h_pol_eff : !h_pol_eff;
            out_sync.v <= v_sync_win ? v_pol_eff : !v_pol_eff;
            out_sync.c <= (h_sync_win || v_sync_win) ? h_pol_eff
                        : !h_pol_eff;
            out_sync.sog <= !(h_sync_win || v_sync_win);
        end
    end

    // field toggles per frame only in interlaced scan
    always_ff @(posedge clk)
    begin
        if (!nrst)
            out_field <= 1'b0;
        else if (!out_set.interlace_flag)
            out_field <= 1'b0;
        else if (line_end && v_cnt_q >= v_end)
            out_field <= !out_field;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            h_blank_total <= 12'h000;
            h_line_total <= 12'h000;
        end
        else
        begin
            h_blank_total <= 12'(out_set.h_front)
                + 12'(out_set.h_sync_width) + 12'(out_set.h_back);
            h_line_total <= h_end + 12'h001;
        end
    end

    // helper: length of the last h sync pulse
    always_ff @(posedge clk)
    begin
        if (!nrst)
            h_run_q <= 12'h000;
        else if (h_sync_q)
            h_run_q <= h_run_q + 12'h001;
        else
            h_run_q <= 12'h000;
    end

    // a pulse cut short by an output set change is not judged
    always_ff @(posedge clk)
    begin
        if (!nrst || (wr_en && wr_ok && wr_sel == SET_OUT))
            h_run_ok_q <= 1'b0;
        else if (line_end && !h_sync_q && !h_sync_win)
            h_run_ok_q <= 1'b1;
    end

    a_hsync_width: assert property ($fell(h_sync_q) &&
        h_run_ok_q |-> h_run_q == 12'(out_set.h_sync_width))
        else $error("h sync width differs from setting");

    a_blank_porch: assert property (!h_act_win |=> out_blank)
        else $error("video not blanked outside active");

    a_three_wire_neg: assert property (
        $past(out_set.sync_fmt) == SYNC_3W && h_sync_q |-> !out_sync.h)
        else $error("three wire sync not negative");

    a_line_wrap: assert property (line_end && !wr_en |=>
        h_cnt_q == 12'h000 ##1 h_cnt_q == 12'h001)
        else $error("line counter did not wrap at line total");

    // ==========================================================
    // input raster measurement
    logic total_valid;

    line_rate_meter #(
        .GATE_CYCLES(GATE_CYCLES),
        .VSEP_CYCLES(VSEP_CYCLES),
        .RATE_MIN(RATE_MIN),
        .RATE_MAX(RATE_MAX)
    ) u_meter (
        .clk(clk),
        .nrst(nrst),
        .in_sync(in_sync),
        .sync_fmt(in_set.sync_fmt),
        .h_pol(in_set.h_sync_polarity),
        .v_pol(in_set.v_sync_polarity),
        .measured_line_rate(measured_line_rate),
        .measured_total_lines(measured_total_lines),
        .total_valid(total_valid),
        .line_rate_in_range(line_rate_in_range)
    );

    always_ff @(posedge clk)
    begin
        if (!nrst)
            v_sum_mismatch <= 1'b0;
        else
            v_sum_mismatch <= total_valid && (12'(in_set.v_front)
                + 12'(in_set.v_sync_width) + 12'(in_set.v_active)
                != measured_total_lines);
    end

endmodule : raster_timing_parameter_set

`default_nettype wire

// [raster_source.sv]
/*
  raster_source: separate-wire raster source feeding the input pins.
  assumes: clocked by the bench clock, syncs synchronous to it.
*/
`timescale 1ns/1ps
`default_nettype none

module raster_source #(
    parameter int HT = 40,
    parameter int SYNC_PIX = 16,
    parameter int VT = 16,
    parameter int SYNC_LINES = 2
) (
    input wire logic clk,
    input wire logic pol,
    output raster_pkg::raster_sync_t sync_o
);
    import raster_pkg::*;
    // ==========================================================
    // counters
    int hc = 0;
    int vc = 0;
    always_ff @(posedge clk)
    begin
        hc <= (hc == HT - 1) ? 0 : hc + 1;
        if (hc == HT - 1)
            vc <= (vc == VT - 1) ? 0 : vc + 1;
    end
    // ==========================================================
    // five-wire pins: each sync on its own wire
    always_comb
    begin
        sync_o.h = (hc < SYNC_PIX) ? pol : !pol;
        sync_o.v = (vc < SYNC_LINES) ? pol : !pol;
        sync_o.c = sync_o.h;
        sync_o.sog = !(hc < SYNC_PIX);
    end
endmodule : raster_source

`default_nettype wire

// [tb_raster_timing_parameter_set.sv]
/*
  tb_raster_timing_parameter_set: directed bench for the timing sets.
  assumes: raster_source drives the input pins in five-wire form.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_raster_timing_parameter_set;
    import raster_pkg::*;
    logic clk = 0;
    logic nrst = 0;
    logic wr_en = 0;
    set_sel_t wr_sel = SET_IN;
    timing_set_t wr_data = '0;
    logic wr_error, query_req = 0, query_busy, query_valid;
    set_sel_t query_sel = SET_IN;
    logic [2:0] query_index;
    logic [10:0] query_word;
    timing_set_t in_set, out_set;
    raster_sync_t in_sync, out_sync;
    logic out_blank, v_sum_mismatch, out_field, rate_ok;
    logic [15:0] line_rate;
    logic [11:0] h_blank_total, h_line_total, measured_total_lines;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;

    // ==========================================================
    // clock, timeout, design and source
    initial
    begin
        forever #4 clk = !clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_fail++;
            final_report();
        end
    end
    raster_timing_parameter_set #(.GATE_CYCLES(2000), .VSEP_CYCLES(50))
    uut (.clk(clk), .nrst(nrst), .wr_en(wr_en), .wr_sel(wr_sel),
        .wr_data(wr_data), .wr_error(wr_error), .query_req(query_req),
        .query_sel(query_sel), .query_busy(query_busy),
        .query_valid(query_valid), .query_index(query_index),
        .query_word(query_word), .in_set(in_set), .out_set(out_set),
        .in_sync(in_sync), .out_sync(out_sync), .out_blank(out_blank),
        .out_field(out_field), .h_blank_total(h_blank_total),
        .h_line_total(h_line_total), .measured_line_rate(line_rate),
        .measured_total_lines(measured_total_lines),
        .line_rate_in_range(rate_ok), .v_sum_mismatch(v_sum_mismatch));
    // positive polarity source, 16 lines of 40 pixels
    raster_source src (.clk(clk), .pol(1'b1), .sync_o(in_sync));

    // ==========================================================
    // helpers
    task automatic chk(string name, logic [15:0] got, logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    function automatic timing_set_t mk(int hf, hs, hb, ha, vf, vs, vb, va,
        sync_fmt_t f, logic hp);
        return '{10'(hf), 10'(hs), 10'(hb), 11'(ha), 10'(vf), 6'(vs),
            10'(vb), 11'(va), f, hp, hp, 1'b0};
    endfunction : mk

    task automatic wr(set_sel_t s, timing_set_t d, logic err);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_sel <= s;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
        chk("wr_error", 16'(wr_error), 16'(err));
    endtask : wr

    task automatic query(set_sel_t s, int w[8]);
        @(posedge clk);
        query_req <= 1'b1;
        query_sel <= s;
        @(posedge clk);
        query_req <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            #1;
            chk("query_valid", 16'(query_valid), 16'h0001);
            chk("query_index", 16'(query_index), 16'(i));
            chk("query_busy", 16'(query_busy), 16'h0001);
            chk("query_word", 16'(query_word), 16'(w[i]));
            @(posedge clk);
        end
        #1;
        chk("query_valid", 16'(query_valid), 16'h0000);
    endtask : query

    // width of one output h sync pulse at level lv
    task automatic hwidth(logic lv, int exp);
        int n;
        n = 0;
        // let a pulse cut short by the set change pass first
        repeat (50) @(posedge clk);
        #1;
        for (int i = 0; i < 300 && out_sync.h !== !lv; i++)
            @(posedge clk) #1;
        for (int i = 0; i < 300 && out_sync.h !== lv; i++)
            @(posedge clk) #1;
        while (out_sync.h === lv && n < 300)
        begin
            chk("out_blank", 16'(out_blank), 16'h0001);
            chk("sog", 16'(out_sync.sog), 16'h0000);
            chk("csync", 16'(out_sync.c), 16'(lv));
            n++;
            @(posedge clk);
            #1;
        end
        chk("h sync width", 16'(n), 16'(exp));
    endtask : hwidth

    // ==========================================================
    // scenarios
    task automatic t_sets;
        query(SET_IN, '{16, 96, 48, 640, 10, 2, 33, 480});
        wr(SET_IN, mk(640, 640, 0, 1920, 512, 32, 0, 1440, SYNC_4W, 0), 0);
        query(SET_IN, '{640, 640, 0, 1920, 512, 32, 0, 1440});
        // the other set keeps its own values
        query(SET_OUT, '{16, 96, 48, 640, 10, 2, 33, 480});
    endtask : t_sets

    task automatic t_refuse;
        wr(SET_IN, mk(641, 16, 0, 16, 0, 2, 0, 12, SYNC_5W, 0), 1);
        wr(SET_IN, mk(0, 15, 0, 16, 0, 2, 0, 12, SYNC_5W, 0), 1);
        wr(SET_IN, mk(0, 16, 641, 16, 0, 2, 0, 12, SYNC_5W, 0), 1);
        wr(SET_IN, mk(0, 16, 0, 1921, 0, 2, 0, 12, SYNC_5W, 0), 1);
        wr(SET_IN, mk(0, 16, 0, 15, 0, 2, 0, 12, SYNC_5W, 0), 1);
        wr(SET_IN, mk(0, 16, 0, 16, 513, 2, 0, 12, SYNC_5W, 0), 1);
        wr(SET_IN, mk(0, 16, 0, 16, 0, 2, 0, 12, sync_fmt_t'(3'h2), 0),
            1);
        wr(SET_IN, mk(0, 16, 0, 16, 0, 33, 0, 12, SYNC_5W, 0), 1);
        wr(SET_IN, mk(0, 16, 0, 16, 0, 1, 0, 12, SYNC_5W, 0), 1);
        wr(SET_IN, mk(0, 16, 0, 16, 0, 2, 513, 12, SYNC_5W, 0), 1);
        wr(SET_IN, mk(0, 16, 0, 16, 0, 2, 0, 11, SYNC_5W, 0), 1);
        wr(SET_IN, mk(0, 16, 0, 16, 0, 2, 0, 1441, SYNC_5W, 0), 1);
        chk("in h_active", 16'(in_set.h_active), 16'h0780);
    endtask : t_refuse

    task automatic t_out;
        timing_set_t s;
        wr(SET_OUT, mk(4, 16, 5, 16, 0, 2, 0, 12, SYNC_5W, 1), 0);
        @(posedge clk);
        #1;
        chk("h_blank_total", 16'(h_blank_total), 16'h0019);
        chk("h_line_total", 16'(h_line_total), 16'h0029);
        hwidth(1'b1, 16);
        wr(SET_OUT, mk(4, 16, 5, 16, 0, 2, 0, 12, SYNC_5W, 0), 0);
        hwidth(1'b0, 16);
        // three wire ignores the flags and runs negative
        wr(SET_OUT, mk(4, 20, 5, 16, 0, 2, 0, 12, SYNC_3W, 1), 0);
        hwidth(1'b0, 20);
        // same raster interlaced: field flips once per 45 x 14 frame
        s = mk(4, 20, 5, 16, 0, 2, 0, 12, SYNC_3W, 1);
        s.interlace_flag = 1'b1;
        wr(SET_OUT, s, 0);
        repeat (630) @(posedge clk);
        #1;
        chk("out_field", 16'(out_field), 16'h0001);
    endtask : t_out

    task automatic t_meas;
        // source frame is 16 lines; front 2 + sync 2 + active 12
        wr(SET_IN, mk(4, 16, 4, 16, 2, 2, 0, 12, SYNC_5W, 1), 0);
        repeat (2000) @(posedge clk);
        #1;
        chk("total lines", 16'(measured_total_lines), 16'h0010);
        chk("v sum mismatch", 16'(v_sum_mismatch), 16'h0000);
        wr(SET_IN, mk(4, 16, 4, 16, 3, 2, 0, 12, SYNC_5W, 1), 0);
        repeat (2000) @(posedge clk);
        #1;
        chk("v sum mismatch", 16'(v_sum_mismatch), 16'h0001);
        // 2000 cycle gate over 40 cycle lines
        chk("line rate", line_rate, 16'h0032);
        chk("rate in range", 16'(rate_ok), 16'h0000);
    endtask : t_meas

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    initial
    begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        t_sets();
        t_refuse();
        t_out();
        t_meas();
        final_report();
    end
endmodule : tb_raster_timing_parameter_set

`default_nettype wire
